// ==== design/cuwpe_pkg.sv ====
// Purpose: Shared constants for the compare unit with PWM entry
// Assumes: 8-bit register port, Timer1 and Timer2 counters live outside this block
// Notes:   Offsets, field positions and mode codes are named here only once
package cuwpe_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the 4-bit register address
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_ALT_PIN = 4'h0; // Alternate pin select
    localparam logic [3:0] ADDR_CTRL1 = 4'h1; // Unit 1 control
    localparam logic [3:0] ADDR_CTRL2 = 4'h2; // Unit 2 control
    localparam logic [3:0] ADDR_CMP1_LO = 4'h3; // Unit 1 compare value low
    localparam logic [3:0] ADDR_CMP1_HI = 4'h4; // Unit 1 compare value high
    localparam logic [3:0] ADDR_CMP2_LO = 4'h5; // Unit 2 compare value low
    localparam logic [3:0] ADDR_CMP2_HI = 4'h6; // Unit 2 compare value high
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7; // Interrupt enables
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h8; // Interrupt flags, write one to clear
    localparam logic [3:0] ADDR_PERIOD = 4'h9; // PWM period value

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int CTRL_W = 6; // Implemented control bits, upper two read zero
    localparam int MODE_LSB = 0; // Mode select position
    localparam int MODE_W = 4; // Mode select width
    localparam int DUTY_LSB = 4; // Duty low bits position
    localparam int DUTY_LO_W = 2; // Duty low bits width
    localparam int IRQ_BIT_U2 = 0; // Unit 2 flag and enable bit
    localparam int IRQ_BIT_U1 = 1; // Unit 1 flag and enable bit
    localparam int IRQ_W = 2; // Implemented interrupt bits
    localparam int ALT_BIT = 0; // Alternate pin select bit

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [7:0] PERIOD_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [7:0] RDATA_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Mode select codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0; // Unit off
    localparam logic [3:0] MODE_TOGGLE = 4'h2; // Toggle pin on match
    localparam logic [3:0] MODE_SET = 4'h8; // Set pin on match
    localparam logic [3:0] MODE_CLEAR = 4'h9; // Clear pin on match
    localparam logic [3:0] MODE_SWI = 4'ha; // Flag only, pin uncontrolled
    localparam logic [3:0] MODE_SPECIAL = 4'hb; // Special event trigger
    localparam logic [1:0] MODE_PWM_TOP = 2'h3; // Upper mode bits for PWM
    localparam logic [9:0] DUTY_ZERO = 10'h000; // Duty value of zero percent

endpackage

// ==== design/cuwpe_unit.sv ====
// Purpose: One compare unit with its output latch and PWM entry
// Assumes: Timer counts are from logic on the same clock
// Notes:   Match event is one pulse per entry into the equal condition
`timescale 1ns/1ps
module cuwpe_unit
    import cuwpe_pkg::*;
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_resetn, // Asynchronous reset, active low
    input wire logic [3:0] i_mode, // Mode select
    input wire logic [1:0] i_duty_low, // Duty low bits
    input wire logic [15:0] i_cmp_value, // Compare value
    input wire logic i_ctrl_clear, // Control register written with zero
    input wire logic [15:0] i_timer_one_count_count, // Timer1 count
    input wire logic [7:0] i_tmr2_count, // Timer2 count
    input wire logic [1:0] i_tmr2_fine, // Two extra time base bits
    input wire logic i_period_hit, // Timer2 period match on its increment
    output logic o_pin, // Compare or PWM output latch
    output logic o_pin_ctl, // Unit controls its pin
    output logic o_match_event, // Match event pulse
    output logic o_special_req // Special trigger level
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic latch; // Compare output latch
        logic match_prev; // Match seen on the previous cycle
        logic [9:0] duty; // Duty value latched at period start
    } cuwpe_unit_s;

    cuwpe_unit_s st_r;
    cuwpe_unit_s st_nxt;
    logic match; // Counts are equal now
    logic rise; // First cycle of equality
    logic is_pwm; // PWM mode selected
    logic is_cmp; // Any compare mode selected
    logic pin_mode; // Compare mode that drives the pin

    // Decode of the mode select
    always_comb
    begin
        match = (i_cmp_value == i_timer_one_count_count);
        rise = match && !st_r.match_prev;
        is_pwm = (i_mode[3:2] == MODE_PWM_TOP);
        pin_mode = (i_mode == MODE_TOGGLE) || (i_mode == MODE_SET) || (i_mode == MODE_CLEAR);
        is_cmp = pin_mode || (i_mode == MODE_SWI) || (i_mode == MODE_SPECIAL);
    end

    // Next state of the latch and the duty buffer
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.match_prev = match;
        if (i_ctrl_clear)
        begin
            // Clearing control drops the latch, not the port latch
            st_nxt.latch = 1'b0;
        end
        else if (is_pwm)
        begin
            if (i_period_hit)
            begin
                // Duty is double buffered so a new value starts glitch free
                st_nxt.duty = {i_cmp_value[7:0], i_duty_low};
                st_nxt.latch = ({i_cmp_value[7:0], i_duty_low} != DUTY_ZERO);
            end
            else if ({i_tmr2_count, i_tmr2_fine} == st_r.duty)
            begin
                st_nxt.latch = 1'b0;
            end
        end
        else if (rise)
        begin
            // Pin action on a match
            case (i_mode)
                MODE_TOGGLE: st_nxt.latch = !st_r.latch;
                MODE_SET: st_nxt.latch = 1'b1;
                MODE_CLEAR: st_nxt.latch = 1'b0;
                default: st_nxt.latch = st_r.latch; // Flag only modes leave it
            endcase
        end
    end

    // State register; compare halts whenever the system clock stops
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign o_pin = st_r.latch;
    assign o_pin_ctl = pin_mode || is_pwm;
    assign o_match_event = is_cmp && rise;
    assign o_special_req = (i_mode == MODE_SPECIAL) && match;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_event_single: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_match_event |=> !o_match_event)
        else $error("match event lasted more than one cycle");

    a_set_on_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (o_match_event && i_mode == MODE_SET && !i_ctrl_clear) |=> o_pin)
        else $error("set mode did not raise latch");

endmodule // cuwpe_unit

// ==== design/cuwpe_top.sv ====
// Purpose: Two compare units with PWM entry, registers and interrupt
// Assumes: Timer1 and Timer2 run outside on the system clock, Timer1 honours the clear request
// Notes:   Summary of operation follows
`timescale 1ns/1ps
module cuwpe_top
    import cuwpe_pkg::*;
(
    input wire logic i_clk_sys, // System clock, 10 MHz
    input wire logic i_resetn, // Asynchronous reset, active low
    input wire logic [3:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Register write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after the strobe
    output logic o_irq, // Interrupt, level
    input wire logic [15:0] i_timer_one_count_count, // Timer1 count
    input wire logic [7:0] i_tmr2_count, // Timer2 count
    input wire logic [1:0] i_tmr2_fine, // Timer2 extra time base bits
    input wire logic i_tmr2_tick, // Timer2 increment pulse
    input wire logic i_adc_enabled, // Converter enabled
    output logic o_timer_one_count_clear, // Clear Timer1 at its next increment
    output logic o_adc_start, // Start conversion pulse
    output logic o_unit1_pin, // Unit 1 pin level
    output logic o_unit1_oe, // Unit 1 drives its pin
    output logic o_unit2_pri_pin, // Unit 2 level on primary pin
    output logic o_unit2_pri_oe, // Unit 2 drives primary pin
    output logic o_unit2_alt_pin, // Unit 2 level on alternate pin
    output logic o_unit2_alt_oe // Unit 2 drives alternate pin
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic alt_sel; // Alternate pin select
        logic [CTRL_W-1:0] ctrl1; // Unit 1 control
        logic [CTRL_W-1:0] ctrl2; // Unit 2 control
        logic [15:0] cmp1; // Unit 1 compare value
        logic [15:0] cmp2; // Unit 2 compare value
        logic [IRQ_W-1:0] irq_en; // Interrupt enables
        logic [IRQ_W-1:0] irq_flag; // Sticky interrupt flags
        logic [7:0] period; // PWM period value
        logic [7:0] rdata; // Read data
        logic irq; // Interrupt output
        logic timer_one_count_clear; // Timer1 clear request
        logic adc_start; // Conversion start pulse
        logic pin1; // Unit 1 pin
        logic oe1; // Unit 1 enable
        logic pin_pri; // Unit 2 primary pin
        logic oe_pri; // Unit 2 primary enable
        logic pin_alt; // Unit 2 alternate pin
        logic oe_alt; // Unit 2 alternate enable
    } cuwpe_top_s;

    cuwpe_top_s st_r;
    cuwpe_top_s st_nxt;
    logic wr_ctrl1_zero; // Unit 1 control written with zero
    logic wr_ctrl2_zero; // Unit 2 control written with zero
    logic period_hit; // Timer2 reached period on its increment
    logic u1_pin; // Unit 1 latch
    logic u1_ctl; // Unit 1 controls pin
    logic u1_event; // Unit 1 match event
    logic u1_special; // Unit 1 special trigger
    logic u2_pin; // Unit 2 latch
    logic u2_ctl; // Unit 2 controls pin
    logic u2_event; // Unit 2 match event
    logic u2_special; // Unit 2 special trigger
    logic [IRQ_W-1:0] events; // Events this cycle
    logic [IRQ_W-1:0] flag_clr; // Write one to clear mask

    // ----------------------------------------------------------------
    // Strobes for the units, the period match shared by both
    // ----------------------------------------------------------------
    // Zero writes and the Timer2 period match
    always_comb
    begin
        wr_ctrl1_zero = i_wr && (i_addr == ADDR_CTRL1) && (i_wdata == RDATA_ZERO);
        wr_ctrl2_zero = i_wr && (i_addr == ADDR_CTRL2) && (i_wdata == RDATA_ZERO);
        period_hit = i_tmr2_tick && (i_tmr2_count == st_r.period);
    end

    // ----------------------------------------------------------------
    // Compare units
    // ----------------------------------------------------------------
    cuwpe_unit u_unit1 (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_mode(st_r.ctrl1[MODE_LSB +: MODE_W]),
        .i_duty_low(st_r.ctrl1[DUTY_LSB +: DUTY_LO_W]),
        .i_cmp_value(st_r.cmp1),
        .i_ctrl_clear(wr_ctrl1_zero),
        .i_timer_one_count_count(i_timer_one_count_count),
        .i_tmr2_count(i_tmr2_count),
        .i_tmr2_fine(i_tmr2_fine),
        .i_period_hit(period_hit),
        .o_pin(u1_pin),
        .o_pin_ctl(u1_ctl),
        .o_match_event(u1_event),
        .o_special_req(u1_special)
    );

    cuwpe_unit u_unit2 (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_mode(st_r.ctrl2[MODE_LSB +: MODE_W]),
        .i_duty_low(st_r.ctrl2[DUTY_LSB +: DUTY_LO_W]),
        .i_cmp_value(st_r.cmp2),
        .i_ctrl_clear(wr_ctrl2_zero),
        .i_timer_one_count_count(i_timer_one_count_count),
        .i_tmr2_count(i_tmr2_count),
        .i_tmr2_fine(i_tmr2_fine),
        .i_period_hit(period_hit),
        .o_pin(u2_pin),
        .o_pin_ctl(u2_ctl),
        .o_match_event(u2_event),
        .o_special_req(u2_special)
    );

    // ----------------------------------------------------------------
    // Register file, interrupt and pin routing
    // ----------------------------------------------------------------
    // Next state; a flag set in the same cycle as its clear survives
    always_comb
    begin
        st_nxt = st_r;
        events = '0;
        events[IRQ_BIT_U1] = u1_event;
        events[IRQ_BIT_U2] = u2_event;
        flag_clr = '0;
        // Register writes
        if (i_wr)
        begin
            case (i_addr)
                ADDR_ALT_PIN: st_nxt.alt_sel = i_wdata[ALT_BIT];
                ADDR_CTRL1: st_nxt.ctrl1 = i_wdata[CTRL_W-1:0];
                ADDR_CTRL2: st_nxt.ctrl2 = i_wdata[CTRL_W-1:0];
                ADDR_CMP1_LO: st_nxt.cmp1[7:0] = i_wdata;
                ADDR_CMP1_HI: st_nxt.cmp1[15:8] = i_wdata;
                ADDR_CMP2_LO: st_nxt.cmp2[7:0] = i_wdata;
                ADDR_CMP2_HI: st_nxt.cmp2[15:8] = i_wdata;
                ADDR_IRQ_EN: st_nxt.irq_en = i_wdata[IRQ_W-1:0];
                ADDR_IRQ_FLAG: flag_clr = i_wdata[IRQ_W-1:0];
                ADDR_PERIOD: st_nxt.period = i_wdata;
                default: st_nxt.period = st_r.period; // Unmapped writes ignored
            endcase
        end
        st_nxt.irq_flag = (st_r.irq_flag & ~flag_clr) | events;
        st_nxt.irq = |(st_nxt.irq_flag & st_nxt.irq_en);
        // Read data stand only in the cycle after the strobe
        st_nxt.rdata = RDATA_ZERO;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_ALT_PIN: st_nxt.rdata = {7'h00, st_r.alt_sel};
                ADDR_CTRL1: st_nxt.rdata = {2'h0, st_r.ctrl1};
                ADDR_CTRL2: st_nxt.rdata = {2'h0, st_r.ctrl2};
                ADDR_CMP1_LO: st_nxt.rdata = st_r.cmp1[7:0];
                ADDR_CMP1_HI: st_nxt.rdata = st_r.cmp1[15:8];
                ADDR_CMP2_LO: st_nxt.rdata = st_r.cmp2[7:0];
                ADDR_CMP2_HI: st_nxt.rdata = st_r.cmp2[15:8];
                ADDR_IRQ_EN: st_nxt.rdata = {6'h00, st_r.irq_en};
                ADDR_IRQ_FLAG: st_nxt.rdata = {6'h00, st_r.irq_flag};
                ADDR_PERIOD: st_nxt.rdata = st_r.period;
                default: st_nxt.rdata = RDATA_ZERO; // Unmapped reads zero
            endcase
        end
        // Level request; Timer1 takes it on its own increment, so a vanished match skips it
        st_nxt.timer_one_count_clear = u1_special || u2_special;
        // The clear request is not an overflow, so the timer sets no overflow flag
        // Conversion start belongs to unit 2 alone
        st_nxt.adc_start = u2_event && (st_r.ctrl2[MODE_LSB +: MODE_W] == MODE_SPECIAL) && i_adc_enabled;
        // Pins; direction stays with software outside this block
        st_nxt.pin1 = u1_pin;
        st_nxt.oe1 = u1_ctl;
        st_nxt.pin_pri = u2_pin && !st_r.alt_sel;
        st_nxt.oe_pri = u2_ctl && !st_r.alt_sel;
        st_nxt.pin_alt = u2_pin && st_r.alt_sel;
        st_nxt.oe_alt = u2_ctl && st_r.alt_sel;
    end

    // State register; all control state starts from zero
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_rdata = st_r.rdata;
    assign o_irq = st_r.irq;
    assign o_timer_one_count_clear = st_r.timer_one_count_clear;
    assign o_adc_start = st_r.adc_start;
    assign o_unit1_pin = st_r.pin1;
    assign o_unit1_oe = st_r.oe1;
    assign o_unit2_pri_pin = st_r.pin_pri;
    assign o_unit2_pri_oe = st_r.oe_pri;
    assign o_unit2_alt_pin = st_r.pin_alt;
    assign o_unit2_alt_oe = st_r.oe_alt;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_zero_ctrl1;
        i_wr && i_addr == ADDR_CTRL1 && i_wdata == RDATA_ZERO;
    endsequence

    sequence s_quiet_ctrl1;
        !(i_wr && i_addr == ADDR_CTRL1) [*2];
    endsequence

    a_zero_ctrl_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        s_zero_ctrl1 ##1 s_quiet_ctrl1 |-> !o_unit1_pin && !o_unit1_oe)
        else $error("unit 1 pin not low after zero control write");

    a_swi_no_pin: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (st_r.ctrl1[MODE_LSB +: MODE_W] == MODE_SWI) [*2] |-> !o_unit1_oe)
        else $error("flag only mode drives the pin");

    a_special_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (st_r.ctrl2[MODE_LSB +: MODE_W] == MODE_SPECIAL && st_r.cmp2 == i_timer_one_count_count) |=> o_timer_one_count_clear)
        else $error("special trigger missed a match");

    a_clear_needs_match: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_timer_one_count_clear |-> $past((st_r.ctrl1[MODE_LSB +: MODE_W] == MODE_SPECIAL && st_r.cmp1 == i_timer_one_count_count)
            || (st_r.ctrl2[MODE_LSB +: MODE_W] == MODE_SPECIAL && st_r.cmp2 == i_timer_one_count_count)))
        else $error("timer clear without a live match");

    a_special_no_pin: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (st_r.ctrl2[MODE_LSB +: MODE_W] == MODE_SPECIAL) [*2] |-> !o_unit2_pri_oe && !o_unit2_alt_oe)
        else $error("special trigger mode drives a unit 2 pin");

    a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (st_r.irq_flag[IRQ_BIT_U2] && !(i_wr && i_addr == ADDR_IRQ_FLAG && i_wdata[IRQ_BIT_U2]))
            |=> st_r.irq_flag[IRQ_BIT_U2])
        else $error("unit 2 flag dropped without a clear");

    // Read data must fall back to zero when no read was taken
    a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !$past(i_rd) |-> o_rdata == RDATA_ZERO)
        else $error("read data stood without a read");

    a_adc_unit2_only: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_adc_start |-> $past(i_adc_enabled && st_r.ctrl2[MODE_LSB +: MODE_W] == MODE_SPECIAL))
        else $error("conversion start outside unit 2 trigger");

    a_alt_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !(o_unit2_alt_oe && o_unit2_pri_oe))
        else $error("unit 2 drives both pins");

    a_flag_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (u1_event && i_wr && i_addr == ADDR_IRQ_FLAG) |=> st_r.irq_flag[IRQ_BIT_U1])
        else $error("match event lost against clear");

    a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (st_r.irq_flag[IRQ_BIT_U2] && st_r.irq_en[IRQ_BIT_U2]) |-> o_irq)
        else $error("unmasked flag without interrupt");

endmodule // cuwpe_top

// ==== tb/cuwpe_timer_one_count_model.sv ====
// Purpose: Timer1 stand-in that honours the clear request of the compare block
// Assumes: Count advances once every four system clocks, like an instruction clock
// Notes:   Overflow is flagged only by counting past all ones, never by a clear
`timescale 1ns/1ps
module cuwpe_timer_one_count_model
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_resetn, // Asynchronous reset, active low
    input wire logic i_clear, // Clear instead of the next increment
    output logic [15:0] o_count, // Timer1 count
    output logic o_ovf // Overflow seen, sticky
);
    // --------------------------------------------------------------
    // Prescaler and counter
    // --------------------------------------------------------------
    logic [1:0] pre_r; // Divide by four, so the timer never runs at the system rate
    // Synchronous counter mode only: all on the one clock
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pre_r <= 2'h0;
            o_count <= 16'h0000;
            o_ovf <= 1'b0;
        end
        else
        begin
            pre_r <= pre_r + 2'h1;
            if (pre_r == 2'h3)
            begin
                // A clear takes the place of the increment
                o_count <= i_clear ? 16'h0000 : o_count + 16'h0001;
                if (!i_clear && o_count == 16'hffff)
                    o_ovf <= 1'b1;
            end
        end
    end
endmodule // cuwpe_timer_one_count_model

// ==== tb/test_compare_unit_with_pwm_entry.sv ====
// Purpose: Self-checking bench for the two compare units
// Assumes: Timer2 is a bench counter ticking every clock
// Notes:   Unit 2 in special mode makes Timer1 wrap, so events recur quickly
`timescale 1ns/1ps
module test_compare_unit_with_pwm_entry;
    import cuwpe_pkg::*;
    // --------------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------------
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, adc_en = 1'b1, clr, ovf, adc, irq;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, tmr2 = 8'h00, per = 8'h03;
    logic [15:0] timer_one_count;
    logic p1, oe1, pp, poe, ap, aoe;
    int num_errors = 0, num_checks = 0, cyc = 0, tog, pls, hi, mx;
    cuwpe_top cuwpe_top_inst (.i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_timer_one_count_count(timer_one_count), .i_tmr2_count(tmr2),
        .i_tmr2_fine(2'h0), .i_tmr2_tick(1'b1), .i_adc_enabled(adc_en), .o_timer_one_count_clear(clr),
        .o_adc_start(adc), .o_unit1_pin(p1), .o_unit1_oe(oe1), .o_unit2_pri_pin(pp),
        .o_unit2_pri_oe(poe), .o_unit2_alt_pin(ap), .o_unit2_alt_oe(aoe));
    cuwpe_timer_one_count_model cuwpe_timer_one_count_model_inst (.i_clk_sys(clk), .i_resetn(rstn), .i_clear(clr),
        .o_count(timer_one_count), .o_ovf(ovf));
    // --------------------------------------------------------------
    // Clock, Timer2 and the hang limit
    // --------------------------------------------------------------
    initial forever #50 clk = ~clk;
    always @(posedge clk)
    begin
        tmr2 <= (tmr2 == per) ? 8'h00 : tmr2 + 8'h01; // Wraps at the bench copy of the period
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1; // A hang counts as a mismatch
            close_out();
        end
    end
    // --------------------------------------------------------------
    // Bus and check tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bw(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic br(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e); // Read data stand only in this cycle
    endtask
    // Watch n cycles: pin changes, start pulses, pin high time, highest Timer1 count
    task automatic watch(input int n);
        logic last;
        tog = 0; pls = 0; hi = 0; mx = 0;
        last = p1;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            tog += (p1 !== last); pls += (adc === 1'b1); hi += (p1 === 1'b1);
            mx = (timer_one_count > mx) ? timer_one_count : mx;
            last = p1;
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 10; a++) br(a[3:0], 8'h00); // Every register resets to zero
        bw(4'hf, 8'hff); br(4'hf, 8'h00); // Unmapped place reads zero
        bw(ADDR_ALT_PIN, 8'hff); br(ADDR_ALT_PIN, 8'h01);
        bw(ADDR_IRQ_EN, 8'hff); br(ADDR_IRQ_EN, 8'h03);
        bw(ADDR_PERIOD, 8'ha5); br(ADDR_PERIOD, 8'ha5);
        bw(ADDR_CTRL2, 8'hff); br(ADDR_CTRL2, 8'h3f);
        bw(ADDR_IRQ_EN, 8'h00); bw(ADDR_ALT_PIN, 8'h00); bw(ADDR_CTRL2, 8'h00); bw(ADDR_IRQ_FLAG, 8'h03);
        $display("test registers done");
        // Second reset restarts Timer1 below the compare values used next
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        br(ADDR_PERIOD, 8'h00); // Mid-run reset clears the period again
        // Unit 2 turns the compare value into the Timer1 period, unit 1 toggles
        bw(ADDR_CMP2_LO, 8'h06); bw(ADDR_CMP1_LO, 8'h02);
        bw(ADDR_CTRL2, {4'h0, MODE_SPECIAL}); bw(ADDR_CTRL1, {4'h0, MODE_TOGGLE});
        repeat (40) @(posedge clk);
        watch(112); // Four Timer1 periods of seven counts
        chk(mx, 16'h0006);
        chk(pls, 16'h0004);
        chk(tog, 16'h0004);
        chk({ovf, poe, oe1}, 3'b001);
        @(posedge clk);
        adc_en <= 1'b0;
        watch(56);
        chk(pls, 16'h0000);
        @(posedge clk);
        adc_en <= 1'b1;
        br(ADDR_IRQ_FLAG, 8'h03);
        chk(irq, 1'b0); // Masked flags keep the line low
        bw(ADDR_IRQ_EN, 8'h01); #1 chk(irq, 1'b1); // Unmasked unit 2 flag
        // Clear both flags in the very cycle of the unit 1 match: the event must win
        wait (timer_one_count == 16'h0001);
        wait (timer_one_count == 16'h0002);
        wr <= 1'b1;
        addr <= ADDR_IRQ_FLAG;
        wdata <= 8'h03;
        @(posedge clk);
        wr <= 1'b0;
        br(ADDR_IRQ_FLAG, 8'h02);
        $display("test special trigger done");
        for (int m = 0; m < 3; m++)
        begin
            bw(ADDR_CTRL1, {4'h0, (m == 0) ? MODE_SET : (m == 1) ? MODE_CLEAR : MODE_SWI});
            repeat (40) @(posedge clk);
            #1 chk({oe1, p1 & oe1}, (m == 0) ? 2'b11 : (m == 1) ? 2'b10 : 2'b00);
        end
        bw(ADDR_CTRL1, {4'h0, MODE_SET}); repeat (40) @(posedge clk);
        bw(ADDR_CTRL1, 8'h00); repeat (2) @(posedge clk);
        #1 chk({p1, oe1}, 2'b00);
        bw(ADDR_CTRL2, 8'h00); bw(ADDR_IRQ_FLAG, 8'h03); br(ADDR_IRQ_FLAG, 8'h00);
        chk(irq, 1'b0); // Cleared flag drops the line
        $display("test pin modes done");
        bw(ADDR_ALT_PIN, 8'h01); bw(ADDR_CTRL2, {4'h0, MODE_SET});
        mx = timer_one_count + 16'h0008; // A match a few counts ahead of the free-running timer
        bw(ADDR_CMP2_HI, mx[15:8]); bw(ADDR_CMP2_LO, mx[7:0]); repeat (40) @(posedge clk);
        #1 chk({ap, aoe, pp, poe}, 4'b1100);
        bw(ADDR_ALT_PIN, 8'h00); repeat (3) @(posedge clk);
        #1 chk({ap, aoe, pp, poe}, 4'b0011);
        bw(ADDR_CTRL2, 8'h00);
        $display("test alternate pin done");
        bw(ADDR_PERIOD, 8'h03); bw(ADDR_CMP1_LO, 8'h00); bw(ADDR_CTRL1, 8'h0c);
        repeat (8) @(posedge clk);
        watch(32); chk({oe1, hi[7:0]}, 9'h100);
        bw(ADDR_CMP1_LO, 8'h02); repeat (8) @(posedge clk);
        watch(32); chk(hi > 0 && hi < 32, 1'b1);
        $display("test pwm done");
        close_out();
    end
endmodule // test_compare_unit_with_pwm_entry
